// ### aq_pkg.sv
// What this block does
// R1: Six read-only data bytes at 0x32..0x37, low/high pairs for x, y, z.
// R2: Samples are two's complement; lower address holds the low byte.
// R3: Host should read all six data bytes in one multi-byte transfer.
// R4: At the two highest output rates the sample word LSB is forced to zero.
// R5: Sample LSB sits at low-byte bit 0 right-aligned, bit 3 left-aligned.
// R6: Control bits 7:6 select bypass, fill-once, rolling or trigger-capture.
// R7: Fill-once stores up to 32 samples, then only when space is freed.
// R8: Rolling keeps the latest 32 samples, overwriting the oldest when full.
// R9: Trigger-capture keeps pre-trigger samples, then fills and stops when full.
// R10: Trigger-source bit picks first interrupt pin (0) or second pin (1).
// R11: A sample count of zero sets the watermark flag at once, any mode.
// R12: Fill-once and rolling: sample count is the watermark level; bypass ignores it.
// R13: Trigger-capture: sample count is the number of pre-trigger samples kept.
// R14: Host must not program count zero while in trigger-capture mode.
// R15: Status bit 7 reads 1 once a trigger event has happened.
// R16: Status bits 5:0 report the number of stored entries.
// R17: Queued samples are read through the six data byte addresses.
// R18: Each read transaction of the data bytes pops one queue level at its end.
// R19: Host must burst-read each entry before that level is discarded.
// R20: Queue holds 32 entries plus one at the output stage, 33 available.
// R21: Sample-ready, watermark and overrun flags set regardless of enables.
// R22: Those flags clear by reading data bytes; ready and watermark may need several.
// R23: Alignment bit 1 selects left-aligned, 0 right-aligned with sign extension.
// R24: While asleep no new samples are written into the queue.
// R25: Watermark asserts when entry count reaches the sample count, fill and rolling.
// R26: Overrun asserts when a sample is dropped or overwrites an unread entry; code sets none for bypass samples lost mid-transfer or pre-trigger discards.
package aq_pkg;

    localparam int unsigned SMP_W = 13;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned LEFT_SHIFT = 3;
    localparam int unsigned Q_DEPTH = 32;
    localparam int unsigned CNT_W = 6;

    localparam logic [5:0] ADDR_X_LO = 6'h32;
    localparam logic [5:0] ADDR_X_HI = 6'h33;
    localparam logic [5:0] ADDR_Y_LO = 6'h34;
    localparam logic [5:0] ADDR_Y_HI = 6'h35;
    localparam logic [5:0] ADDR_Z_LO = 6'h36;
    localparam logic [5:0] ADDR_Z_HI = 6'h37;
    localparam logic [5:0] ADDR_CTL = 6'h38;
    localparam logic [5:0] ADDR_STAT = 6'h39;

    localparam int unsigned CTL_MODE_LO = 6;
    localparam int unsigned CTL_TRIG_SEL = 5;
    localparam int unsigned CTL_SAMPLES_W = 5;
    localparam int unsigned STAT_TRIG_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;

    localparam int unsigned CMD_RD_BIT = 7;
    localparam int unsigned CMD_MB_BIT = 6;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {AQ_BYPASS, AQ_FILL, AQ_ROLL, AQ_TRIG} aq_mode_e;
    typedef enum logic [1:0] {AQ_SPI_IDLE, AQ_SPI_CMD, AQ_SPI_DATA} aq_spi_e;

    typedef struct packed {
        logic signed [SMP_W-1:0] x;
        logic signed [SMP_W-1:0] y;
        logic signed [SMP_W-1:0] z;
    } aq_sample_s;

    typedef struct packed {
        logic sleep;
        logic rate_high;
        logic left_align;
    } aq_fmt_s;

    typedef struct packed {
        logic sample_ready;
        logic watermark;
        logic overrun;
    } aq_flags_s;

endpackage

// ### aq_top.sv
`timescale 1ns/1ps

module aq_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    // Level
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign o_out_valid = (count_q != '0);
    // A full queue still takes a word when the same cycle drains one
    assign o_in_ready = (count_q != (AW+1)'(DEPTH)) || i_out_ready;
    assign pop = o_out_valid && i_out_ready;
    assign push = i_in_valid && o_in_ready;
    assign o_out_data = mem[rd_ptr_q];
    assign o_count = count_q;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || i_clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

module aq_top
    import aq_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Serial register port
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // Sensor samples
    input wire logic i_smp_valid,
    input wire aq_sample_s i_smp,
    // Device state
    input wire aq_fmt_s i_fmt,
    input wire logic i_first_interrupt_pin,
    input wire logic i_second_interrupt_pin,
    // Status
    output aq_flags_s o_flags,
    output logic o_trigger_seen_flag
);
    function automatic logic [WORD_W-1:0] aq_format(input logic [SMP_W-1:0] v, input aq_fmt_s f);
        logic [SMP_W-1:0] s;
        s = v;
        if (f.rate_high) begin
            s[0] = 1'b0; // see R4
        end
        if (f.left_align) begin
            aq_format = {s, {LEFT_SHIFT{1'b0}}}; // see R5, R23
        end else begin
            aq_format = {{(WORD_W-SMP_W){s[SMP_W-1]}}, s}; // see R2, R5, R23
        end
    endfunction

    function automatic logic aq_is_data(input logic [5:0] a);
        aq_is_data = (a >= ADDR_X_LO) && (a <= ADDR_Z_HI);
    endfunction

    // Link pin synchronisers; first stage feeds only the second
    logic [2:0] sclk_sync_q;
    logic [2:0] cs_sync_q;
    logic [1:0] mosi_sync_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_start;
    logic cs_end;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sclk_sync_q <= 3'h7;
            cs_sync_q <= 3'h7;
            mosi_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], i_spi_sclk};
            cs_sync_q <= {cs_sync_q[1:0], i_spi_cs_n};
            mosi_sync_q <= {mosi_sync_q[0], i_spi_mosi};
        end
    end

    assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
    assign sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];
    assign cs_start = !cs_sync_q[1] && cs_sync_q[2];
    assign cs_end = cs_sync_q[1] && !cs_sync_q[2];

    // Serial command decoding
    aq_spi_e spi_st_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [5:0] ptr_q;
    logic rd_q;
    logic mb_q;
    logic [7:0] tx_q;
    logic data_read_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic ctl_wr;
    logic busy;
    logic pop_evt;
    logic [7:0] rd_byte;

    assign rx_byte = {shift_q, mosi_sync_q[1]};
    assign byte_done = sclk_rise && (bit_cnt_q == LAST_BIT);
    assign ctl_wr = byte_done && (spi_st_q == AQ_SPI_DATA) && !rd_q && (ptr_q == ADDR_CTL);
    assign busy = (spi_st_q != AQ_SPI_IDLE);
    assign pop_evt = cs_end && data_read_q; // see R18

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            spi_st_q <= AQ_SPI_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
            ptr_q <= 6'h00;
            rd_q <= 1'b0;
            mb_q <= 1'b0;
        end else if (cs_start) begin
            spi_st_q <= AQ_SPI_CMD;
            bit_cnt_q <= 3'h0;
        end else if (cs_end) begin
            spi_st_q <= AQ_SPI_IDLE;
        end else if (sclk_rise && busy) begin
            shift_q <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done) begin
                case (spi_st_q)
                    AQ_SPI_CMD: begin
                        rd_q <= rx_byte[CMD_RD_BIT];
                        mb_q <= rx_byte[CMD_MB_BIT];
                        ptr_q <= rx_byte[5:0];
                        spi_st_q <= AQ_SPI_DATA;
                    end
                    AQ_SPI_DATA: begin
                        if (mb_q) begin
                            ptr_q <= ptr_q + 6'h01; // see R1
                        end
                    end
                    default: spi_st_q <= AQ_SPI_IDLE;
                endcase
            end
        end
    end

    // Reply byte loads on the falling edge that opens each byte
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tx_q <= 8'h00;
        end else if (sclk_fall && busy) begin
            if (bit_cnt_q == 3'h0) begin
                tx_q <= rd_byte;
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // A data read anywhere in the burst pops once at deselect
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || cs_start) begin
            data_read_q <= 1'b0;
        end else if (sclk_fall && (spi_st_q == AQ_SPI_DATA) && rd_q && (bit_cnt_q == 3'h0)
                     && aq_is_data(ptr_q)) begin
            data_read_q <= 1'b1; // see R17, R18
        end
    end

    assign o_spi_miso = tx_q[7];
    assign o_spi_miso_oe = (spi_st_q == AQ_SPI_DATA) && rd_q;

    // Control register and queue state
    logic [7:0] ctl_q;
    aq_mode_e mode;
    logic [CNT_W-1:0] samples;
    aq_sample_s hold_q;
    logic hold_valid_q;
    logic trig_prev_q;
    logic trig_seen_q;
    aq_flags_s flags_q;
    logic [CNT_W-1:0] q_count;
    logic q_full;
    logic q_push;
    logic q_drop;
    logic q_refill;
    logic q_in_ready;
    logic q_out_valid;
    aq_sample_s q_out;
    logic byp_load;
    logic ovr_evt;
    logic trig_pin;
    logic trig_rise;
    logic wm_cond;
    logic flush;
    logic [WORD_W-1:0] x_word;
    logic [WORD_W-1:0] y_word;
    logic [WORD_W-1:0] z_word;

    assign mode = aq_mode_e'(ctl_q[7:CTL_MODE_LO]); // see R6
    assign samples = {1'b0, ctl_q[CTL_SAMPLES_W-1:0]};
    assign q_full = (q_count == CNT_W'(Q_DEPTH));
    assign flush = ctl_wr && (rx_byte[7:CTL_MODE_LO] == 2'b00);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctl_q <= CTL_RESET;
        end else if (ctl_wr) begin
            ctl_q <= rx_byte;
        end
    end

    // Routing of each incoming sample by queue mode
    always_comb begin
        q_push = 1'b0;
        q_drop = 1'b0;
        ovr_evt = 1'b0;
        byp_load = 1'b0;
        if (i_smp_valid) begin
            case (mode)
                AQ_BYPASS: begin
                    // Held back mid-burst so the host sees one coherent sample
                    byp_load = !busy;
                    ovr_evt = !busy && hold_valid_q; // see R26
                end
                AQ_FILL: begin
                    if (!i_fmt.sleep) begin // see R24
                        q_push = !q_full; // see R7
                        ovr_evt = q_full; // see R26
                    end
                end
                AQ_ROLL: begin
                    if (!i_fmt.sleep) begin // see R24
                        q_push = 1'b1;
                        q_drop = q_full; // see R8
                        ovr_evt = q_full; // see R26
                    end
                end
                AQ_TRIG: begin
                    if (!i_fmt.sleep) begin // see R24
                        if (trig_seen_q) begin
                            q_push = !q_full; // see R9
                            ovr_evt = q_full;
                        end else begin
                            q_push = 1'b1;
                            q_drop = (q_count >= samples); // see R13
                        end
                    end
                end
                default: begin
                    q_push = 1'b0;
                end
            endcase
        end
    end

    assign q_refill = !hold_valid_q && !busy && q_out_valid && (mode != AQ_BYPASS);

    aq_fifo #(
        .WIDTH($bits(aq_sample_s)),
        .DEPTH(Q_DEPTH)
    ) u_queue (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_clear(flush),
        .i_in_valid(q_push),
        .o_in_ready(q_in_ready),
        .i_in_data(i_smp),
        .o_out_valid(q_out_valid),
        .i_out_ready(q_refill || q_drop),
        .o_out_data(q_out),
        .o_count(q_count)
    );

    // Output stage: the 33rd entry the host can see
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            hold_q <= '0;
            hold_valid_q <= 1'b0;
        end else if (pop_evt) begin
            hold_valid_q <= 1'b0; // see R18
        end else if (byp_load) begin
            hold_q <= i_smp;
            hold_valid_q <= 1'b1;
        end else if (q_refill) begin
            hold_q <= q_out; // see R17, R20
            hold_valid_q <= 1'b1;
        end
    end

    // Trigger capture; a new event beats a control write clear
    assign trig_pin = ctl_q[CTL_TRIG_SEL] ? i_second_interrupt_pin : i_first_interrupt_pin; // see R10
    assign trig_rise = trig_pin && !trig_prev_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            trig_prev_q <= 1'b0;
            trig_seen_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_pin;
            if (ctl_wr) begin
                trig_seen_q <= 1'b0;
            end
            if ((mode == AQ_TRIG) && trig_rise) begin
                trig_seen_q <= 1'b1; // see R9, R15
            end
        end
    end

    // Event flags; every set wins over a same-cycle read clear
    assign wm_cond = (samples == '0)
                     || (((mode == AQ_FILL) || (mode == AQ_ROLL)) && (q_count >= samples));

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flags_q <= '0;
        end else begin
            if (pop_evt) begin
                flags_q.overrun <= 1'b0; // see R22
                flags_q.watermark <= 1'b0;
                if (q_count == '0) begin
                    flags_q.sample_ready <= 1'b0;
                end
            end
            if (byp_load || q_push) begin
                flags_q.sample_ready <= 1'b1; // see R21
            end
            if (wm_cond) begin
                flags_q.watermark <= 1'b1; // see R11, R12, R25
            end
            if (ovr_evt) begin
                flags_q.overrun <= 1'b1; // see R26
            end
        end
    end

    assign o_flags = flags_q;
    assign o_trigger_seen_flag = trig_seen_q;

    // Register read mux
    assign x_word = aq_format(hold_q.x, i_fmt);
    assign y_word = aq_format(hold_q.y, i_fmt);
    assign z_word = aq_format(hold_q.z, i_fmt);

    always_comb begin
        rd_byte = 8'h00;
        case (ptr_q)
            ADDR_X_LO: rd_byte = x_word[7:0]; // see R1, R2
            ADDR_X_HI: rd_byte = x_word[15:8];
            ADDR_Y_LO: rd_byte = y_word[7:0];
            ADDR_Y_HI: rd_byte = y_word[15:8];
            ADDR_Z_LO: rd_byte = z_word[7:0];
            ADDR_Z_HI: rd_byte = z_word[15:8];
            ADDR_CTL: rd_byte = ctl_q;
            ADDR_STAT: rd_byte = {trig_seen_q, 1'b0, q_count}; // see R15, R16
            default: rd_byte = 8'h00;
        endcase
    end

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    sequence s_burst_read;
        data_read_q ##1 (data_read_q && cs_end);
    endsequence

    property p_rate_lsb;
        i_fmt.rate_high && !i_fmt.left_align |-> (x_word[0] == 1'b0) && (z_word[0] == 1'b0);
    endproperty
    a_rate_lsb: assert property (p_rate_lsb) else $error("LSB not forced at high rate"); // see R4

    property p_left_align;
        i_fmt.left_align |-> (y_word == {hold_q.y[SMP_W-1:1], hold_q.y[0] && !i_fmt.rate_high, 3'h0});
    endproperty
    a_left_align: assert property (p_left_align) else $error("Left alignment wrong"); // see R5

    property p_sign_ext;
        !i_fmt.left_align |-> ($signed(x_word) == $signed({hold_q.x[SMP_W-1:1],
                                  hold_q.x[0] && !i_fmt.rate_high}));
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("Sign extension wrong"); // see R2

    property p_fill_stop;
        // A refill or flush in the same cycle legally lowers the count
        (mode == AQ_FILL) && q_full && i_smp_valid && !i_fmt.sleep && hold_valid_q && !flush
            |-> ##1 flags_q.overrun && (q_count == $past(q_count));
    endproperty
    a_fill_stop: assert property (p_fill_stop) else $error("Full queue took a sample"); // see R7

    property p_roll_keep;
        (mode == AQ_ROLL) && q_full && i_smp_valid && !i_fmt.sleep && hold_valid_q && !flush
            |=> (q_count == CNT_W'(Q_DEPTH)) && flags_q.overrun;
    endproperty
    a_roll_keep: assert property (p_roll_keep) else $error("Rolling queue lost depth"); // see R8

    property p_count_max;
        q_count <= CNT_W'(Q_DEPTH);
    endproperty
    a_count_max: assert property (p_count_max) else $error("Queue above 32"); // see R20

    property p_wm_zero;
        ctl_wr && (rx_byte[CTL_SAMPLES_W-1:0] == '0) |-> ##2 flags_q.watermark;
    endproperty
    a_wm_zero: assert property (p_wm_zero) else $error("Zero count did not set watermark"); // see R11

    property p_trig_seen;
        // A control write right after the event may clear the flag again
        (mode == AQ_TRIG) && trig_rise |=> trig_seen_q ##1 (trig_seen_q || $past(ctl_wr));
    endproperty
    a_trig_seen: assert property (p_trig_seen) else $error("Trigger not recorded"); // see R15

    property p_pop;
        s_burst_read |=> !hold_valid_q;
    endproperty
    a_pop: assert property (p_pop) else $error("Read burst did not pop"); // see R18

    property p_sleep;
        i_fmt.sleep && (mode != AQ_BYPASS) |=> (q_count <= $past(q_count));
    endproperty
    a_sleep: assert property (p_sleep) else $error("Queue grew while asleep"); // see R24

    property p_push_ok;
        q_push |-> q_in_ready;
    endproperty
    a_push_ok: assert property (p_push_ok) else $error("Queue pushed while unable to take"); // see R20
endmodule

// ### aq_host_model.sv
`timescale 1ns/1ps
module aq_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Serial port, mode 3
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    // Received bytes
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_byte = 8'h00;
    end
    always @(posedge i_sys_clk) begin
        if (o_rd_valid) begin
            o_rd_valid <= 1'b0;
        end
    end
    // Half period of 4 clk; command byte then nb data bytes in one frame
    task automatic frame(input logic [7:0] cmd, input int nb, input logic [7:0] wd);
        logic [7:0] tx;
        logic [7:0] rx;
        tx = cmd;
        @(posedge i_sys_clk) o_cs_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        for (int b = 0; b <= nb; b++) begin
            for (int i = 7; i >= 0; i--) begin
                @(posedge i_sys_clk) o_sclk <= 1'b0;
                o_mosi <= tx[i];
                repeat (4) @(posedge i_sys_clk);
                o_sclk <= 1'b1;
                rx = {rx[6:0], i_miso};
                repeat (3) @(posedge i_sys_clk);
            end
            if (b > 0 && cmd[7]) begin
                o_rd_byte <= rx;
                o_rd_valid <= 1'b1;
            end
            tx = wd;
        end
        repeat (4) @(posedge i_sys_clk);
        o_cs_n <= 1'b1;
        // Released data line must not look held
        o_mosi <= ~o_mosi;
        repeat (5) @(posedge i_sys_clk);
    endtask
endmodule

// ### aq_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module aq_tb_top
    import aq_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic sclk, cs_n, mosi, miso, miso_oe, miso_w, rd_valid, trig_seen;
    logic idle_q = 1'b0;
    logic smp_valid = 1'b0;
    logic pin1 = 1'b0;
    logic pin2 = 1'b0;
    logic [7:0] rd_byte, ev;
    aq_sample_s smp = '0;
    aq_fmt_s fmt = '0;
    aq_flags_s flags;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] expq[$];
    aq_sample_s hist[$];

    always #2 i_sys_clk = ~i_sys_clk;
    // Undriven miso shows a toggling pattern
    always @(posedge i_sys_clk) idle_q <= ~idle_q;
    assign miso_w = miso_oe ? miso : idle_q;

    aq_top DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_smp_valid(smp_valid),
        .i_smp(smp), .i_fmt(fmt), .i_first_interrupt_pin(pin1), .i_second_interrupt_pin(pin2),
        .o_flags(flags), .o_trigger_seen_flag(trig_seen));
    aq_host_model host (.i_sys_clk(i_sys_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso_w), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            close_out();
        end
    end

    always @(posedge i_sys_clk) begin
        if (rd_valid) begin
            ev = (expq.size() != 0) ? expq.pop_front() : 8'hxx;
            `CHK(rd_byte, ev)
        end
    end

    function automatic logic [15:0] word(input logic [12:0] s);
        logic [12:0] t;
        t = {s[12:1], s[0] && !fmt.rate_high};
        word = fmt.left_align ? {t, 3'b000} : {{3{t[12]}}, t};
    endfunction

    function automatic logic [7:0] xlo(input aq_sample_s s);
        logic [15:0] w;
        w = word(s.x);
        return w[7:0];
    endfunction

    task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
        expq.push_back(e);
        host.frame(cmd, 1, 8'h00);
    endtask

    task automatic wr(input logic [7:0] d);
        host.frame(8'h38, 1, d);
    endtask

    task automatic burst(input aq_sample_s s);
        logic [15:0] w[3];
        w[0] = word(s.x);
        w[1] = word(s.y);
        w[2] = word(s.z);
        for (int a = 0; a < 3; a++) begin
            expq.push_back(w[a][7:0]);
            expq.push_back(w[a][15:8]);
        end
        host.frame(8'hf2, 6, 8'h00);
    endtask

    task automatic drain(input int first, input int last);
        for (int i = first; i <= last; i++) begin
            rd(8'hb2, xlo(hist[i]));
        end
        rd(8'hb9, 8'h00);
    endtask

    task automatic push(input int n);
        logic [63:0] r;
        repeat (n) begin
            r = {$urandom, $urandom};
            @(posedge i_sys_clk) smp <= r[38:0];
            smp_valid <= 1'b1;
            hist.push_back(r[38:0]);
            @(posedge i_sys_clk) smp_valid <= 1'b0;
            repeat (3) @(posedge i_sys_clk);
        end
    endtask

    task automatic pulse(input int p);
        @(posedge i_sys_clk) pin1 <= (p == 1);
        pin2 <= (p == 2);
        @(posedge i_sys_clk) pin1 <= 1'b0;
        pin2 <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
    endtask

    initial begin
        logic [7:0] m;
        void'($urandom(32'hbe4d));
        repeat (5) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        `CHK(flags.watermark, 1'b1)
        rd(8'hb8, 8'h00);
        rd(8'h80, 8'h00);
        host.frame(8'h39, 1, 8'hff);
        rd(8'hb9, 8'h00);
        // Nonzero count kept in each of the four modes
        for (int i = 0; i < 4; i++) begin
            m = {i[1:0], 6'h25};
            wr(m);
            rd(8'hb8, m);
        end
        wr(8'h00);
        $display("test registers done at %0t", $time);
        for (int f = 0; f < 4; f++) begin
            @(posedge i_sys_clk) fmt <= {1'b0, f[0], f[1]};
            push(1);
            `CHK(flags.sample_ready, 1'b1)
            burst(hist[f]);
            `CHK(flags.sample_ready, 1'b0)
        end
        @(posedge i_sys_clk) fmt <= '0;
        $display("test bypass done at %0t", $time);
        wr(8'h44);
        rd(8'hb2, xlo(hist[3]));
        hist.delete();
        push(4);
        `CHK(flags.watermark, 1'b0)
        @(posedge i_sys_clk) fmt.sleep <= 1'b1;
        push(1);
        void'(hist.pop_back());
        @(posedge i_sys_clk) fmt.sleep <= 1'b0;
        rd(8'hb9, 8'h03);
        push(1);
        `CHK(flags.watermark, 1'b1)
        push(29);
        void'(hist.pop_back());
        `CHK(flags.overrun, 1'b1)
        rd(8'hb9, 8'h20);
        drain(0, 32);
        `CHK(flags.overrun, 1'b0)
        $display("test fill done at %0t", $time);
        wr(8'h90);
        hist.delete();
        push(40);
        `CHK(flags.overrun, 1'b1)
        rd(8'hb9, 8'h20);
        burst(hist[0]);
        burst(hist[8]);
        drain(9, 39);
        $display("test rolling done at %0t", $time);
        wr(8'he3);
        hist.delete();
        push(10);
        rd(8'hb9, 8'h03);
        pulse(1);
        `CHK(trig_seen, 1'b0)
        pulse(2);
        `CHK(trig_seen, 1'b1)
        push(31);
        `CHK(flags.overrun, 1'b1)
        rd(8'hb9, 8'ha0);
        burst(hist[0]);
        burst(hist[7]);
        wr(8'hc3);
        `CHK(trig_seen, 1'b0)
        pulse(2);
        `CHK(trig_seen, 1'b0)
        pulse(1);
        `CHK(trig_seen, 1'b1)
        $display("test trigger done at %0t", $time);
        close_out();
    end
endmodule
